// ===== dv/apcr_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module apcr_top_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [1:0] st0 = 2'h0;
  logic [1:0] st1 = 2'h0;
  wire [31:0] rdat;
  wire ack;
  wire [21:0] f0;
  wire [21:0] f1;
  wire [12:0] d0;
  wire [12:0] d1;
  logic [7:0] m [8];
  logic [7:0] mask [4] = '{8'hFF, 8'h0B, 8'h3F, 8'h1F};
  logic [7:0] rv [4] = '{8'h8B, 8'h02, 8'h2B, 8'h00};
  logic [7:0] r = 8'h5F;
  int failures = 0;
  int checked = 0;

  apcr_top DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .loop0_digital_state_field(st0),
    .loop1_digital_state_field(st1), .loop0_pump_current(f0[21:19]),
    .loop0_filter_series_res(f0[18:17]), .loop0_filter_par_cap(f0[16:15]),
    .loop0_filter_zero_sel(f0[14]), .loop0_synth_select(f0[13]),
    .loop0_lock_count_sel(f0[12]), .loop0_lock_manual(f0[11]),
    .loop0_manual_vco_pick(f0[10]), .loop0_vco_a_lock_code(f0[9:5]),
    .loop0_vco_b_lock_code(f0[4:0]), .loop0_ref_from_inputs(d0[12]),
    .loop0_ref_from_crystal(d0[11]), .loop0_pump_current_ua(d0[10:1]),
    .loop0_state_mismatch(d0[0]), .loop1_pump_current(f1[21:19]),
    .loop1_filter_series_res(f1[18:17]), .loop1_filter_par_cap(f1[16:15]),
    .loop1_filter_zero_sel(f1[14]), .loop1_synth_select(f1[13]),
    .loop1_lock_count_sel(f1[12]), .loop1_lock_manual(f1[11]),
    .loop1_manual_vco_pick(f1[10]), .loop1_vco_a_lock_code(f1[9:5]),
    .loop1_vco_b_lock_code(f1[4:0]), .loop1_ref_from_inputs(d1[12]),
    .loop1_ref_from_crystal(d1[11]), .loop1_pump_current_ua(d1[10:1]),
    .loop1_state_mismatch(d1[0]));

  // 125 MHz clock
  always #4 clk = ~clk;

  // Pseudo-random source, fixed start value
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic end_of_test;
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Model view of one loop's derived outputs
  function automatic logic [12:0] derived(input int l);
    logic syn;
    int ua;
    syn = m[l*4+1][3];
    ua = (m[l*4][7:5] + 1) * 110;
    return {~syn, syn, ua[9:0], syn && ((l ? st1 : st0) != 2'h3)};
  endfunction

  // Expected read data; reserved bits and holes read as zero here
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    logic [9:0] k;
    logic [12:0] e0;
    logic [12:0] e1;
    k = a[11:2] - 10'h0AC;
    e0 = derived(0);
    e1 = derived(1);
    if (k < 10'h008)
      return {24'h000000, m[k[2:0]]};
    if (a[11:2] == 10'h0C0)
      return {28'h0000000, e1[11], e0[11], e1[0], e0[0]};
    return 32'h00000000;
  endfunction

  // Classic single cycle; ack sampled at the edge before updates land
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic s0, output logic [31:0] rd);
    int n;
    logic [9:0] k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= {3'h7, s0};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      end_of_test();
    end
    else
    begin
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      k = a[11:2] - 10'h0AC;
      if (w && s0 && k < 10'h008)
        m[k[2:0]] = d & mask[k[1:0]];
      @(posedge clk);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a);
    logic [31:0] rd;
    wb(1'b0, a, 8'h00, 1'b0, rd);
    chk("read data", rd, exp_rd(a));
  endtask

  // Fields land on the ack edge, derived values one cycle later
  task automatic settle;
    int l;
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (l = 0; l < 2; l++)
    begin
      chk("fields", l ? f1 : f0, {m[l*4], m[l*4+1][3], m[l*4+1][1:0],
        m[l*4+2][5:0], m[l*4+3][4:0]});
      chk("derived", l ? d1 : d0, derived(l));
    end
    @(posedge clk);
  endtask

  task automatic rd_all;
    int i;
    for (i = 0; i < 8; i++)
      rd_chk(12'h2B0 + 12'(i * 4));
    rd_chk(12'h300);
    rd_chk(12'h104);
  endtask

  task automatic do_reset;
    int i;
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++)
      m[i] = rv[i % 4];
    settle();
    rd_all();
  endtask

  initial
  begin
    logic [31:0] rd;
    int c;
    int l;
    logic [1:0] b;
    do_reset();
    // Every pump code on both loops
    for (c = 0; c < 16; c++)
    begin
      r = lfsr(r);
      wb(1'b1, c[0] ? 12'h2C0 : 12'h2B0, {c[3:1], r[4:0]}, 1'b1, rd);
      settle();
    end
    // Synth select against each digital state code
    for (c = 0; c < 8; c++)
    begin
      l = c % 2;
      if (l)
        st1 <= c[2:1];
      else
        st0 <= c[2:1];
      wb(1'b1, l ? 12'h2C4 : 12'h2B4, 8'h08, 1'b1, rd);
      settle();
      rd_chk(12'h300);
    end
    wb(1'b1, 12'h2B4, 8'h02, 1'b1, rd);
    settle();
    // Random traffic; reserved bits always written as zero
    for (c = 0; c < 40; c++)
    begin
      r = lfsr(r);
      b = r[1:0];
      l = r[2];
      st0 <= r[4:3];
      st1 <= r[6:5];
      r = lfsr(r);
      wb(1'b1, 12'h2B0 + 12'(l * 16) + {8'h00, b, 2'h0},
        r & mask[b], c[2:0] != 3'h5, rd);
      rd_chk(12'h2B0 + 12'(l * 16) + {8'h00, b, 2'h0});
      settle();
    end
    // Writes to status and a hole change nothing
    wb(1'b1, 12'h300, 8'hFF, 1'b1, rd);
    wb(1'b1, 12'h104, 8'hFF, 1'b1, rd);
    rd_all();
    settle();
    do_reset();
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== logic/apcr_cfg.svh
`ifndef APCR_CFG_SVH
`define APCR_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define APCR_IDX_L0_B0 10'h0AC
`define APCR_IDX_L0_B1 10'h0AD
`define APCR_IDX_L0_B2 10'h0AE
`define APCR_IDX_L0_B3 10'h0AF
`define APCR_IDX_L1_B0 10'h0B0
`define APCR_IDX_L1_B1 10'h0B1
`define APCR_IDX_L1_B2 10'h0B2
`define APCR_IDX_L1_B3 10'h0B3
`define APCR_IDX_STATUS 10'h0C0

// Byte numbers inside one loop bank
`define APCR_BYTE_PUMP 2'h0
`define APCR_BYTE_MODE 2'h1
`define APCR_BYTE_VCOA 2'h2
`define APCR_BYTE_VCOB 2'h3

// Field positions
`define APCR_F_PUMP 7:5
`define APCR_F_SERIES 4:3
`define APCR_F_CAP 2:1
`define APCR_F_FILT 0
`define APCR_F_SYNTH 3
`define APCR_F_LCNT 1
`define APCR_F_LMAN 0
`define APCR_F_VCO 5
`define APCR_F_CODE 4:0

// Reset values
`define APCR_RST_PUMP 3'h4
`define APCR_RST_SERIES 2'h1
`define APCR_RST_CAP 2'h1
`define APCR_RST_FILT 1'h1
`define APCR_RST_SYNTH 1'h0
`define APCR_RST_LCNT 1'h1
`define APCR_RST_LMAN 1'h0
`define APCR_RST_VCO 1'h1
`define APCR_RST_CODE_A 5'h0B
`define APCR_RST_CODE_B 5'h00

// Pump current step and the digital state code meaning forced free-run
`define APCR_PUMP_STEP_UA 10'h06E
`define APCR_RST_PUMP_UA 10'h226
`define APCR_STATE_FREERUN 2'h3

`endif

// ===== logic/apcr_loop_mode.sv
`timescale 1ns/1ps
`default_nettype none
`include "apcr_cfg.svh"

module apcr_loop_mode (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic synth,
  input wire logic [2:0] pump,
  input wire logic [1:0] dig_state,
  output logic ref_inputs,
  output logic ref_crystal,
  output logic [9:0] pump_ua,
  output logic mismatch
);

  apcr_pkg::apcr_mode_t st_reg;
  apcr_pkg::apcr_mode_t st_next;

  // Reference source, pump current in uA and a synth/free-run consistency flag
  always_comb
  begin
    st_next.ref_inputs = !synth;
    st_next.ref_crystal = synth;
    st_next.pump_ua = 10'((10'(pump) + 10'h001) * `APCR_PUMP_STEP_UA);
    // Only flags misuse; the loop cannot force the digital state itself
    st_next.mismatch = synth && (dig_state != `APCR_STATE_FREERUN);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_reg <= {1'h1, 1'h0, `APCR_RST_PUMP_UA, 1'h0};
    else
      st_reg <= st_next;
  end

  assign ref_inputs = st_reg.ref_inputs;
  assign ref_crystal = st_reg.ref_crystal;
  assign pump_ua = st_reg.pump_ua;
  assign mismatch = st_reg.mismatch;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  crystal_ref_a: assert property (synth |=> ref_crystal && !ref_inputs)
    else $error("synth mode did not select crystal reference");
  input_ref_a: assert property (!synth |=> ref_inputs && !ref_crystal)
    else $error("normal mode did not select input references");
  pump_ua_a: assert property (##1
    pump_ua == 10'(($past(pump) + 1) * 110))
    else $error("pump current in uA wrong");
  mismatch_a: assert property (synth && dig_state == 2'h0 |=> mismatch)
    else $error("synth without free-run not flagged");

endmodule
`default_nettype wire

// ===== logic/apcr_loop_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "apcr_cfg.svh"

module apcr_loop_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_byte,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_byte,
  output logic [7:0] rd_data,
  output apcr_pkg::apcr_bank_t bank
);

  apcr_pkg::apcr_bank_t bank_reg;
  apcr_pkg::apcr_bank_t bank_next;

  assign bank = bank_reg;

  // Reserved positions are not stored, so a stray one written is dropped
  always_comb
  begin
    bank_next = bank_reg;
    if (wr_en)
    begin
      case (wr_byte)
        `APCR_BYTE_PUMP:
        begin
          bank_next.pump = wr_data[`APCR_F_PUMP];
          bank_next.series = wr_data[`APCR_F_SERIES];
          bank_next.cap = wr_data[`APCR_F_CAP];
          bank_next.filt = wr_data[`APCR_F_FILT];
        end
        `APCR_BYTE_MODE:
        begin
          bank_next.synth = wr_data[`APCR_F_SYNTH];
          bank_next.lcnt = wr_data[`APCR_F_LCNT];
          bank_next.lman = wr_data[`APCR_F_LMAN];
        end
        `APCR_BYTE_VCOA:
        begin
          bank_next.vco = wr_data[`APCR_F_VCO];
          bank_next.code_a = wr_data[`APCR_F_CODE];
        end
        default:
          bank_next.code_b = wr_data[`APCR_F_CODE];
      endcase
    end
  end

  // Reserved bits read as zero
  always_comb
  begin
    rd_data = 8'h00;
    case (rd_byte)
      `APCR_BYTE_PUMP:
        rd_data = {bank_reg.pump, bank_reg.series, bank_reg.cap,
                   bank_reg.filt};
      `APCR_BYTE_MODE:
      begin
        rd_data[`APCR_F_SYNTH] = bank_reg.synth;
        rd_data[`APCR_F_LCNT] = bank_reg.lcnt;
        rd_data[`APCR_F_LMAN] = bank_reg.lman;
      end
      `APCR_BYTE_VCOA:
      begin
        rd_data[`APCR_F_VCO] = bank_reg.vco;
        rd_data[`APCR_F_CODE] = bank_reg.code_a;
      end
      default:
        rd_data[`APCR_F_CODE] = bank_reg.code_b;
    endcase
  end

  // Defaults loaded at reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bank_reg <= {`APCR_RST_PUMP, `APCR_RST_SERIES, `APCR_RST_CAP,
                   `APCR_RST_FILT, `APCR_RST_SYNTH, `APCR_RST_LCNT,
                   `APCR_RST_LMAN, `APCR_RST_VCO, `APCR_RST_CODE_A,
                   `APCR_RST_CODE_B};
    else
      bank_reg <= bank_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  pump_reset_val_a: assert property ($rose(reset_n) |-> bank.pump == 3'h4)
    else $error("pump current not at reset default");
  bank_hold_a: assert property (!wr_en |=> $stable(bank_reg))
    else $error("bank changed without a write");

endmodule
`default_nettype wire

// ===== logic/apcr_pkg.sv
package apcr_pkg;

  // One loop's analog settings
  typedef struct packed {
    logic [2:0] pump;
    logic [1:0] series;
    logic [1:0] cap;
    logic filt;
    logic synth;
    logic lcnt;
    logic lman;
    logic vco;
    logic [4:0] code_a;
    logic [4:0] code_b;
  } apcr_bank_t;

  // Derived loop mode, all registered
  typedef struct packed {
    logic ref_inputs;
    logic ref_crystal;
    logic [9:0] pump_ua;
    logic mismatch;
  } apcr_mode_t;

  typedef enum logic [1:0] {
    apcr_wb_idle = 2'h1,
    apcr_wb_ack = 2'h2
  } apcr_wb_state_t;

  typedef struct packed {
    apcr_wb_state_t st;
    logic ack;
    logic [31:0] dat;
  } apcr_wb_t;

endpackage

// ===== logic/apcr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "apcr_cfg.svh"

module apcr_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] loop0_digital_state_field,
  input wire logic [1:0] loop1_digital_state_field,
  output logic [2:0] loop0_pump_current,
  output logic [1:0] loop0_filter_series_res,
  output logic [1:0] loop0_filter_par_cap,
  output logic loop0_filter_zero_sel,
  output logic loop0_synth_select,
  output logic loop0_lock_count_sel,
  output logic loop0_lock_manual,
  output logic loop0_manual_vco_pick,
  output logic [4:0] loop0_vco_a_lock_code,
  output logic [4:0] loop0_vco_b_lock_code,
  output logic loop0_ref_from_inputs,
  output logic loop0_ref_from_crystal,
  output logic [9:0] loop0_pump_current_ua,
  output logic loop0_state_mismatch,
  output logic [2:0] loop1_pump_current,
  output logic [1:0] loop1_filter_series_res,
  output logic [1:0] loop1_filter_par_cap,
  output logic loop1_filter_zero_sel,
  output logic loop1_synth_select,
  output logic loop1_lock_count_sel,
  output logic loop1_lock_manual,
  output logic loop1_manual_vco_pick,
  output logic [4:0] loop1_vco_a_lock_code,
  output logic [4:0] loop1_vco_b_lock_code,
  output logic loop1_ref_from_inputs,
  output logic loop1_ref_from_crystal,
  output logic [9:0] loop1_pump_current_ua,
  output logic loop1_state_mismatch
);

  localparam logic [9:0] L0_BASE = `APCR_IDX_L0_B0;
  localparam logic [9:0] L1_BASE = `APCR_IDX_L1_B0;

  apcr_pkg::apcr_wb_t wb_reg;
  apcr_pkg::apcr_wb_t wb_next;
  apcr_pkg::apcr_bank_t bank0;
  apcr_pkg::apcr_bank_t bank1;

  logic [9:0] idx;
  logic hit0;
  logic hit1;
  logic hit_status;
  logic mapped;
  logic wr_commit;
  logic [7:0] rd0;
  logic [7:0] rd1;
  logic [3:0] status;
  logic [31:0] rd_word;

  // Word index and bank decode; byte lanes below the word are ignored
  assign idx = wb_adr_i[11:2];
  assign hit0 = idx[9:2] == L0_BASE[9:2];
  assign hit1 = idx[9:2] == L1_BASE[9:2];
  assign hit_status = idx == `APCR_IDX_STATUS;
  assign mapped = hit0 || hit1 || hit_status;

  // Writes land on the edge at which the master samples ack;
  // only lane 0 carries register data, so sel[0] gates the write
  assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_reg.ack &&
                     wb_sel_i[0];

  // Status word: consistency flags and live reference source
  assign status = {loop1_ref_from_crystal, loop0_ref_from_crystal,
                   loop1_state_mismatch, loop0_state_mismatch};

  // Read mux; unmapped words read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit0)
      rd_word = {24'h00_0000, rd0};
    else if (hit1)
      rd_word = {24'h00_0000, rd1};
    else if (hit_status)
      rd_word = {28'h000_0000, status};
  end

  // Bus handshake: ack one cycle after the request, then one idle cycle
  always_comb
  begin
    wb_next = wb_reg;
    case (wb_reg.st)
      apcr_pkg::apcr_wb_idle:
      begin
        wb_next.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i)
        begin
          wb_next.ack = 1'b1;
          wb_next.dat = wb_we_i ? 32'h0000_0000 : rd_word;
          wb_next.st = apcr_pkg::apcr_wb_ack;
        end
      end
      apcr_pkg::apcr_wb_ack:
      begin
        // Forced idle cycle so a held strobe is not taken twice
        wb_next.ack = 1'b0;
        wb_next.st = apcr_pkg::apcr_wb_idle;
      end
      default:
      begin
        wb_next.ack = 1'b0;
        wb_next.st = apcr_pkg::apcr_wb_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wb_reg <= {apcr_pkg::apcr_wb_idle, 1'b0, 32'h0000_0000};
    else
      wb_reg <= wb_next;
  end

  assign wb_ack_o = wb_reg.ack;
  assign wb_dat_o = wb_reg.dat;

  // Loop 0 bank at indices 0AC..0AF
  apcr_loop_regs u_bank0 (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_commit && hit0),
    .wr_byte(idx[1:0]),
    .wr_data(wb_dat_i[7:0]),
    .rd_byte(idx[1:0]),
    .rd_data(rd0),
    .bank(bank0)
  );

  // Loop 1 bank at indices 0B0..0B3
  apcr_loop_regs u_bank1 (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_commit && hit1),
    .wr_byte(idx[1:0]),
    .wr_data(wb_dat_i[7:0]),
    .rd_byte(idx[1:0]),
    .rd_data(rd1),
    .bank(bank1)
  );

  // Loop 0 reference source and pump current
  apcr_loop_mode u_mode0 (
    .clk(clk),
    .reset_n(reset_n),
    .synth(bank0.synth),
    .pump(bank0.pump),
    .dig_state(loop0_digital_state_field),
    .ref_inputs(loop0_ref_from_inputs),
    .ref_crystal(loop0_ref_from_crystal),
    .pump_ua(loop0_pump_current_ua),
    .mismatch(loop0_state_mismatch)
  );

  // Loop 1 reference source and pump current
  apcr_loop_mode u_mode1 (
    .clk(clk),
    .reset_n(reset_n),
    .synth(bank1.synth),
    .pump(bank1.pump),
    .dig_state(loop1_digital_state_field),
    .ref_inputs(loop1_ref_from_inputs),
    .ref_crystal(loop1_ref_from_crystal),
    .pump_ua(loop1_pump_current_ua),
    .mismatch(loop1_state_mismatch)
  );

  // Stored fields go straight out to the analog loops
  assign loop0_pump_current = bank0.pump;
  assign loop0_filter_series_res = bank0.series;
  assign loop0_filter_par_cap = bank0.cap;
  assign loop0_filter_zero_sel = bank0.filt;
  assign loop0_synth_select = bank0.synth;
  assign loop0_lock_count_sel = bank0.lcnt;
  assign loop0_lock_manual = bank0.lman;
  assign loop0_manual_vco_pick = bank0.vco;
  assign loop0_vco_a_lock_code = bank0.code_a;
  assign loop0_vco_b_lock_code = bank0.code_b;
  assign loop1_pump_current = bank1.pump;
  assign loop1_filter_series_res = bank1.series;
  assign loop1_filter_par_cap = bank1.cap;
  assign loop1_filter_zero_sel = bank1.filt;
  assign loop1_synth_select = bank1.synth;
  assign loop1_lock_count_sel = bank1.lcnt;
  assign loop1_lock_manual = bank1.lman;
  assign loop1_manual_vco_pick = bank1.vco;
  assign loop1_vco_a_lock_code = bank1.code_a;
  assign loop1_vco_b_lock_code = bank1.code_b;

  // Helpers read only by the checks below
  logic [2:0] dat_pump;
  logic dat_synth;
  assign dat_pump = wb_dat_i[`APCR_F_PUMP];
  assign dat_synth = wb_dat_i[`APCR_F_SYNTH];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence wr_l1_s(logic [9:0] idx_c);
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o &&
    idx == idx_c;
  endsequence

  ack_timing_a: assert property (req_s |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  pump_write_a: assert property (wr_l1_s(`APCR_IDX_L1_B0) |=>
    loop1_pump_current == $past(dat_pump))
    else $error("loop 1 pump current write lost");
  pump_ua_path_a: assert property (wr_l1_s(`APCR_IDX_L1_B0) ##1
    loop1_pump_current == 3'h7 |=> loop1_pump_current_ua == 10'h370)
    else $error("top pump code did not give 880 uA");
  synth_write_a: assert property (wr_l1_s(`APCR_IDX_L1_B1) |=>
    loop1_synth_select == $past(dat_synth) ##1
    loop1_ref_from_crystal == loop1_synth_select)
    else $error("loop 1 synth select write lost");
  loop0_crystal_a: assert property (loop0_synth_select |=>
    loop0_ref_from_crystal && !loop0_ref_from_inputs)
    else $error("loop 0 synth mode not on crystal");
  unmapped_read_a: assert property (wb_ack_o && !wb_we_i && !mapped |->
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  reserved_read_a: assert property (wb_ack_o && !wb_we_i &&
    (hit0 || hit1) |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("bits above the byte not zero");

  // Committed write to one loop 0 word
  sequence wr_l0_s(logic [9:0] idx_c);
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o &&
    idx == idx_c;
  endsequence

  // Read answer with the request still held by the master
  sequence ack_rd_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
  endsequence

  // Loop 1 in synth mode with its digital state forced to free-run
  sequence l1_freerun_s;
    loop1_synth_select &&
    loop1_digital_state_field == `APCR_STATE_FREERUN;
  endsequence

  // Loop 0 bank takes its writes the same way as loop 1
  pump0_write_a: assert property (wr_l0_s(`APCR_IDX_L0_B0) |=>
    loop0_pump_current == $past(dat_pump))
    else $error("loop 0 pump current write lost");
  synth0_write_a: assert property (wr_l0_s(`APCR_IDX_L0_B1) |=>
    loop0_synth_select == $past(dat_synth) ##1
    loop0_ref_from_crystal == loop0_synth_select)
    else $error("loop 0 synth select write lost");
  loop0_inputs_a: assert property (!loop0_synth_select |=>
    loop0_ref_from_inputs && !loop0_ref_from_crystal)
    else $error("loop 0 normal mode not on input references");

  // Writes that must leave both banks alone
  lane_gate_a: assert property (wb_ack_o && wb_we_i && !wb_sel_i[0] |=>
    $stable(bank0) && $stable(bank1))
    else $error("write with lane 0 off changed a register");
  unmapped_write_a: assert property (wb_ack_o && wb_we_i && !(hit0 || hit1)
    |=> $stable(bank0) && $stable(bank1))
    else $error("write outside the banks changed a register");

  // Read answers carry the fields as stored; no write lands in between
  pump_read_a: assert property (ack_rd_s ##0 hit1 &&
    idx[1:0] == `APCR_BYTE_PUMP |->
    wb_dat_o[`APCR_F_PUMP] == loop1_pump_current)
    else $error("loop 1 pump current read wrong");
  synth_read_a: assert property (ack_rd_s ##0 hit1 &&
    idx[1:0] == `APCR_BYTE_MODE |->
    wb_dat_o[`APCR_F_SYNTH] == loop1_synth_select)
    else $error("loop 1 synth select read wrong");

  // Status answers with the values present when the read was taken
  status_xtal_a: assert property (ack_rd_s ##0 hit_status |->
    wb_dat_o[2] == $past(loop0_ref_from_crystal))
    else $error("status crystal bit wrong");
  status_flag_a: assert property (ack_rd_s ##0 hit_status |->
    wb_dat_o[0] == $past(loop0_state_mismatch))
    else $error("status mismatch bit wrong");

  // Pump code to current, lowest code and default code
  pump_low_a: assert property (loop1_pump_current == 3'h0 |=>
    loop1_pump_current_ua == 10'h06E)
    else $error("lowest pump code did not give 110 uA");
  pump_rst_a: assert property (loop1_pump_current == `APCR_RST_PUMP |=>
    loop1_pump_current_ua == 10'h226)
    else $error("default pump code did not give 550 uA");

  // Consistency flag stays low when software followed the rule
  freerun_ok_a: assert property (l1_freerun_s |=>
    !loop1_state_mismatch)
    else $error("free-run synth mode flagged as mismatch");
  normal_ok_a: assert property (!loop0_synth_select |=>
    !loop0_state_mismatch)
    else $error("normal mode flagged as mismatch");

  // Ack only answers a request, and is quiet right after reset
  ack_cause_a: assert property (wb_ack_o |->
    $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  ack_reset_a: assert property ($rose(reset_n) |-> !wb_ack_o)
    else $error("ack high right after reset");

endmodule
`default_nettype wire
